// file: rtl/output_signal_allocator.sv
// holds the wishbone-reached allocation registers and the output contacts
// assumes status signals synchronous to clk and a classic wishbone master
`timescale 1ns/100ps
// Function
// - three writable map registers decide which contact carries each signal
// - a separate polarity register sets active level of each contact
// - a zero digit routes its signal to no contact
// - first map: alarm, ready, zero speed, brake in digits one to four
// - second map: position, torque limit, speed limit, speed achieved
// - third map digit one routes the warning signal
module output_signal_allocator #(
  parameter int NUM_OUT = out_alloc_pkg::NUM_OUT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic alarmFlag,
  input wire logic readyFlag,
  input wire logic zero_speed_flag,
  input wire logic brakeFlag,
  input wire logic position_reached_flag,
  input wire logic torque_limit_flag,
  input wire logic speed_limit_flag,
  input wire logic speed_achieved_flag,
  input wire logic warningFlag,
  output logic [NUM_OUT-1:0] contacts
);
  localparam int NS = out_alloc_pkg::NUM_SIG;

  // ============================================================
  // registers
  logic [15:0] output_map_first, next_output_map_first;
  logic [15:0] output_map_second, next_output_map_second;
  logic [15:0] output_map_third, next_output_map_third;
  logic [NUM_OUT-1:0] output_polarity_setting, next_output_polarity_setting;
  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;
  logic [NUM_OUT-1:0] next_contacts;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] sel);
    merge16 = old;
    if (sel[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction

  // one decoder feeds both the read mux and the write strobes, so the two
  // can never disagree about which register an address reaches
  typedef enum logic [2:0] {
    REG_MAP_FIRST,
    REG_MAP_SECOND,
    REG_MAP_THIRD,
    REG_POLARITY,
    REG_CONTACTS,
    REG_NONE
  } reg_sel_e;

  function automatic reg_sel_e decode_reg(input logic [4:0] a);
    unique case (a)
      5'(out_alloc_pkg::OFF_MAP_FIRST): decode_reg = REG_MAP_FIRST;
      5'(out_alloc_pkg::OFF_MAP_SECOND): decode_reg = REG_MAP_SECOND;
      5'(out_alloc_pkg::OFF_MAP_THIRD): decode_reg = REG_MAP_THIRD;
      5'(out_alloc_pkg::OFF_POLARITY): decode_reg = REG_POLARITY;
      out_alloc_pkg::OFF_CONTACTS: decode_reg = REG_CONTACTS;
      default: decode_reg = REG_NONE;
    endcase
  endfunction

  // ============================================================
  // wishbone slave: ack one cycle after request, dropped the next cycle
  logic req;
  reg_sel_e target;
  assign req = wb_cyc_i && wb_stb_i && !ack;
  assign target = decode_reg(wb_adr_i[4:0]);

  // read data is latched with ack and holds until the next request replaces it
  always_comb begin
    next_ack = req;
    next_rdata = rdata;
    if (req) begin
      unique case (target)
        REG_MAP_FIRST: next_rdata = {16'h0, output_map_first};
        REG_MAP_SECOND: next_rdata = {16'h0, output_map_second};
        REG_MAP_THIRD: next_rdata = {16'h0, output_map_third};
        REG_POLARITY: next_rdata = 32'(output_polarity_setting);
        REG_CONTACTS: next_rdata = 32'(contacts);
        default: next_rdata = 32'h0;
      endcase
    end
  end

  // writes land on the edge that raises ack; unmapped writes are dropped
  always_comb begin
    next_output_map_first = output_map_first;
    next_output_map_second = output_map_second;
    next_output_map_third = output_map_third;
    next_output_polarity_setting = output_polarity_setting;
    if (req && wb_we_i) begin
      unique case (target)
        REG_MAP_FIRST:
          next_output_map_first =
            merge16(output_map_first, wb_dat_i, wb_sel_i);
        REG_MAP_SECOND:
          next_output_map_second =
            merge16(output_map_second, wb_dat_i, wb_sel_i);
        REG_MAP_THIRD:
          next_output_map_third =
            merge16(output_map_third, wb_dat_i, wb_sel_i);
        REG_POLARITY:
          if (wb_sel_i[0]) begin
            next_output_polarity_setting = wb_dat_i[NUM_OUT-1:0];
          end
        default: ;
      endcase
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;

  // ============================================================
  // routing
  logic [NS-1:0] status;
  logic [NS*4-1:0] digits;
  logic [NUM_OUT-1:0] routed;

  // nibble of the digit vector that belongs to status signal s
  function automatic int slot(input int s);
    slot = s * out_alloc_pkg::DIGIT_W;
  endfunction

  always_comb begin
    status = '0;
    status[out_alloc_pkg::SIG_ALARM] = alarmFlag;
    status[out_alloc_pkg::SIG_READY] = readyFlag;
    status[out_alloc_pkg::SIG_ZERO_SPEED] = zero_speed_flag;
    status[out_alloc_pkg::SIG_BRAKE] = brakeFlag;
    status[out_alloc_pkg::SIG_POS_REACHED] = position_reached_flag;
    status[out_alloc_pkg::SIG_TORQUE_LIMIT] = torque_limit_flag;
    status[out_alloc_pkg::SIG_SPEED_LIMIT] = speed_limit_flag;
    status[out_alloc_pkg::SIG_SPEED_ACHIEVED] = speed_achieved_flag;
    status[out_alloc_pkg::SIG_WARNING] = warningFlag;
  end

  // digit n of a map sits in nibble n-1, lowest first
  // each digit lands beside its signal's bit in the status vector, so the
  // two stay paired whatever order the signals are numbered in
  always_comb begin
    digits = '0;
    digits[slot(out_alloc_pkg::SIG_ALARM) +: 4] =
      output_map_first[3:0];
    digits[slot(out_alloc_pkg::SIG_READY) +: 4] =
      output_map_first[7:4];
    digits[slot(out_alloc_pkg::SIG_ZERO_SPEED) +: 4] =
      output_map_first[11:8];
    digits[slot(out_alloc_pkg::SIG_BRAKE) +: 4] =
      output_map_first[15:12];
    digits[slot(out_alloc_pkg::SIG_POS_REACHED) +: 4] =
      output_map_second[3:0];
    digits[slot(out_alloc_pkg::SIG_TORQUE_LIMIT) +: 4] =
      output_map_second[7:4];
    digits[slot(out_alloc_pkg::SIG_SPEED_LIMIT) +: 4] =
      output_map_second[11:8];
    digits[slot(out_alloc_pkg::SIG_SPEED_ACHIEVED) +: 4] =
      output_map_second[15:12];
    digits[slot(out_alloc_pkg::SIG_WARNING) +: 4] =
      output_map_third[3:0];
  end

  // only contacts 1..5 are driven; zero or 6..e select nothing
  // so exchanging two digits moves each signal to the other contact
  contact_router #(
    .NUM_SIG(NS),
    .NUM_OUT(NUM_OUT)
  ) router (
    .digits(digits),
    .signals(status),
    .contacts(routed)
  );

  // F marks a signal as always allocated; it owns no contact of its own,
  // so the router lets it select nothing, like any other spare code

  // polarity bit set inverts that contact, applied after routing, so an
  // unrouted contact with its bit set rests high
  always_comb begin
    next_contacts = routed ^ output_polarity_setting;
  end

  // ============================================================
  // state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      rdata <= 32'h0;
    end else if (clkEn) begin
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      output_map_first <= out_alloc_pkg::RST_MAP_FIRST;
      output_map_second <= out_alloc_pkg::RST_MAP_SECOND;
      output_map_third <= out_alloc_pkg::RST_MAP_THIRD;
      output_polarity_setting <= NUM_OUT'(out_alloc_pkg::RST_POLARITY);
    end else if (clkEn) begin
      output_map_first <= next_output_map_first;
      output_map_second <= next_output_map_second;
      output_map_third <= next_output_map_third;
      output_polarity_setting <= next_output_polarity_setting;
    end
  end

  // contacts stay low through reset whatever the polarity says
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      contacts <= '0;
    end else if (clkEn) begin
      contacts <= next_contacts;
    end
  end
endmodule

// file: rtl/out_alloc_pkg.sv
// holds register offsets, field layout and reset values of the output allocator
// assumes a 32-bit classic wishbone bus with byte addressing
package out_alloc_pkg;
  // ============================================================
  // register offsets (byte addresses)
  localparam logic [3:0] OFF_MAP_FIRST = 4'h0;
  localparam logic [3:0] OFF_MAP_SECOND = 4'h4;
  localparam logic [3:0] OFF_MAP_THIRD = 4'h8;
  localparam logic [3:0] OFF_POLARITY = 4'hc;
  // ============================================================
  // reset values
  localparam logic [15:0] RST_MAP_FIRST = 16'h4321;
  localparam logic [15:0] RST_MAP_SECOND = 16'h0005;
  localparam logic [15:0] RST_MAP_THIRD = 16'h0000;
  localparam logic [4:0] RST_POLARITY = 5'h00;
  // ============================================================
  // digit encoding
  localparam int DIGIT_W = 4;
  localparam int NUM_SIG = 9;
  localparam int NUM_OUT = 5;
  localparam logic [3:0] DIGIT_NONE = 4'h0;
  localparam logic [3:0] DIGIT_ALWAYS = 4'hf;
  // signal positions in the status vector
  localparam int SIG_ALARM = 0;
  localparam int SIG_READY = 1;
  localparam int SIG_ZERO_SPEED = 2;
  localparam int SIG_BRAKE = 3;
  localparam int SIG_POS_REACHED = 4;
  localparam int SIG_TORQUE_LIMIT = 5;
  localparam int SIG_SPEED_LIMIT = 6;
  localparam int SIG_SPEED_ACHIEVED = 7;
  localparam int SIG_WARNING = 8;
  // read-only mirror of the output contacts
  localparam logic [4:0] OFF_CONTACTS = 5'h10;
endpackage

// file: rtl/contact_router.sv
// holds the combinational digit-to-contact router
// assumes digits are stable around the clock edge that samples the result
`timescale 1ns/100ps
module contact_router #(
  parameter int NUM_SIG = 9,
  parameter int NUM_OUT = 5
) (
  input wire logic [NUM_SIG*4-1:0] digits,
  input wire logic [NUM_SIG-1:0] signals,
  output logic [NUM_OUT-1:0] contacts
);
  // ============================================================
  // routing
  function automatic logic hits(input logic [3:0] d, input int k);
    // value k+1 selects contact k; zero and unknown codes hit nothing
    hits = (d == 4'(k + 1));
  endfunction

  always_comb begin
    logic [3:0] d;
    d = 4'h0;
    contacts = '0;
    for (int s = 0; s < NUM_SIG; s++) begin
      d = digits[s*4 +: 4];
      for (int k = 0; k < NUM_OUT; k++) begin
        // a signal only asserts a contact; or-ing lets two share one
        if (hits(d, k) && signals[s]) begin
          contacts[k] = 1'b1;
        end
      end
    end
  end
endmodule

// file: bench/out_alloc_monitor.sv
// checker: bus handshake and the routing left by reset
// assumes binding into output_signal_allocator
`timescale 1ns/100ps
module out_alloc_monitor #(
  parameter int NUM_OUT = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic alarmFlag,
  input wire logic readyFlag,
  input wire logic zero_speed_flag,
  input wire logic brakeFlag,
  input wire logic position_reached_flag,
  input wire logic [NUM_OUT-1:0] contacts
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // any access may replace the reset map, so stop trusting it then
  logic used;
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      used <= 1'b0;
    else if (wb_ack_o)
      used <= 1'b1;
  end
  sequence take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn;
  endsequence
  sequence fresh;
    !used && !$past(rst) && $past(clkEn);
  endsequence
  // ==========================================
  // assertions
  ack_take_a: assert property (take |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_pulse_a: assert property (wb_ack_o && clkEn |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  alarm_route_a: assert property (
    fresh |-> contacts[0] == $past(alarmFlag))
    else $error("alarm not on contact one");
  ready_route_a: assert property (
    fresh |-> contacts[1] == $past(readyFlag))
    else $error("ready not on contact two");
  zero_route_a: assert property (
    fresh |-> contacts[2] == $past(zero_speed_flag))
    else $error("zero speed not on contact three");
  brake_route_a: assert property (
    fresh |-> contacts[3] == $past(brakeFlag))
    else $error("brake not on contact four");
  pos_route_a: assert property (
    fresh |-> contacts[4] == $past(position_reached_flag))
    else $error("contact five not position only");
endmodule
bind output_signal_allocator out_alloc_monitor #(.NUM_OUT(NUM_OUT)) mon (
  .clk(clk), .rst(rst), .clkEn(clkEn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .alarmFlag(alarmFlag),
  .readyFlag(readyFlag), .zero_speed_flag(zero_speed_flag),
  .brakeFlag(brakeFlag), .position_reached_flag(position_reached_flag),
  .contacts(contacts));

// file: bench/contact_reader.sv
// external controller model: latches the output contacts each edge
// assumes contacts are levels synchronous to clk
`timescale 1ns/100ps
module contact_reader (
  input wire logic clk,
  input wire logic [4:0] contacts,
  output logic [4:0] seen
);
  always_ff @(posedge clk) begin
    seen <= contacts;
  end
endmodule

// file: bench/tb.sv
// testbench of the output allocator
// assumes the design answers a bus request one cycle after taking it
`timescale 1ns/100ps
module tb;
  typedef struct {logic [15:0] m1, m2, m3; logic [4:0] pol, ex;
    logic [8:0] fl;} row_s;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, en = 1, ack;
  logic [31:0] adr = 0, dat = 0, rdat, q;
  logic [3:0] sel = 4'hf;
  logic [8:0] fl = 0;
  logic [4:0] contacts, seen;
  int fails = 0, compares = 0;
  // flags bit 0 alarm .. bit 8 warning
  row_s rows[5] = '{
    '{16'h0301, 16'h5400, 16'h0002, 5'h00, 5'h0b, 9'h141},
    '{16'h4123, 16'h0000, 16'h0000, 5'h00, 5'h01, 9'h004},
    '{16'hf6e0, 16'h0000, 16'h0000, 5'h00, 5'h00, 9'h1ff},
    '{16'h0021, 16'h0000, 16'h0000, 5'h11, 5'h10, 9'h001},
    '{16'h0000, 16'h3210, 16'h0000, 5'h00, 5'h04, 9'h080}};
  output_signal_allocator uut (.clk(clk), .rst(rst), .clkEn(en),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_we_i(we),
    .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .alarmFlag(fl[0]), .readyFlag(fl[1]), .zero_speed_flag(fl[2]),
    .brakeFlag(fl[3]), .position_reached_flag(fl[4]),
    .torque_limit_flag(fl[5]), .speed_limit_flag(fl[6]),
    .speed_achieved_flag(fl[7]), .warningFlag(fl[8]),
    .contacts(contacts));
  contact_reader far (.clk(clk), .contacts(contacts), .seen(seen));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // ==========================================
  // tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wb(input logic w, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {27'h0, a};
    dat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    print_verdict;
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    fl <= 9'h1ff;
    repeat (4) @(posedge clk);
    chk(contacts, 5'h1f);
    wb(0, {1'b0, out_alloc_pkg::OFF_MAP_FIRST}, 0, q);
    chk(q, {16'h0, out_alloc_pkg::RST_MAP_FIRST});
    wb(0, {1'b0, out_alloc_pkg::OFF_MAP_SECOND}, 0, q);
    chk(q, {16'h0, out_alloc_pkg::RST_MAP_SECOND});
    wb(0, {1'b0, out_alloc_pkg::OFF_MAP_THIRD}, 0, q);
    chk(q, {16'h0, out_alloc_pkg::RST_MAP_THIRD});
    wb(0, 5'h14, 0, q);
    chk(q, 32'h0);
    foreach (rows[i]) begin
      wb(1, {1'b0, out_alloc_pkg::OFF_MAP_FIRST}, {16'h0, rows[i].m1}, q);
      wb(1, {1'b0, out_alloc_pkg::OFF_MAP_SECOND}, {16'h0, rows[i].m2}, q);
      wb(1, {1'b0, out_alloc_pkg::OFF_MAP_THIRD}, {16'h0, rows[i].m3}, q);
      wb(1, {1'b0, out_alloc_pkg::OFF_POLARITY}, {27'h0, rows[i].pol}, q);
      fl <= rows[i].fl;
      repeat (3) @(posedge clk);
      chk({27'h0, seen}, {27'h0, rows[i].ex});
    end
    wb(0, {1'b0, out_alloc_pkg::OFF_MAP_SECOND}, 0, q);
    chk(q, 32'h3210);
    wb(0, out_alloc_pkg::OFF_CONTACTS, 0, q);
    chk(q, 32'h4);
    // byte lanes: low lane only on a map, polarity refuses a high lane
    sel <= 4'h1;
    wb(1, {1'b0, out_alloc_pkg::OFF_MAP_SECOND}, 32'h7788, q);
    sel <= 4'h2;
    wb(1, {1'b0, out_alloc_pkg::OFF_POLARITY}, 32'h1f, q);
    sel <= 4'hf;
    wb(0, {1'b0, out_alloc_pkg::OFF_MAP_SECOND}, 0, q);
    chk(q, 32'h3288);
    wb(0, {1'b0, out_alloc_pkg::OFF_POLARITY}, 0, q);
    chk(q, 32'h0);
    // clock enable low holds the contacts against a flag change
    en <= 1'b0;
    fl <= 9'h1ff;
    repeat (3) @(posedge clk);
    chk(contacts, 5'h04);
    en <= 1'b1;
    repeat (2) @(posedge clk);
    chk(contacts, 5'h06);
    // reset in mid-run restores the default map
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(contacts, 5'h00);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(contacts, 5'h1f);
    wb(0, {1'b0, out_alloc_pkg::OFF_MAP_SECOND}, 0, q);
    chk(q, {16'h0, out_alloc_pkg::RST_MAP_SECOND});
    print_verdict;
  end
endmodule
